// ==== hdl/powerdown_reset_sequencer.sv ====
// Powerdown entry and exit sequencer with reset pin handling.
`timescale 1ns/1ps
// Summary of operation
// - Powerdown entered only when request bit is 1 and halt executes.
// - Only the interrupt or the reset pin ends powerdown.
// - Interrupt exit waits a restart delay before clocks are re-enabled.
// - Restart delay is timed on the push-pull timer pin and its capacitor.
// - Reset pin exit skips the capacitor-timed restart delay.
// - Reset pin low aborts bus cycles and returns state to initial values.
// - During reset all pins held in a defined state, reset indicator high.
// - Reset indicator stays high while reset pin is low, drops after release.
// - Interrupt assertion is latched so a brief pulse still requests service.
module powerdown_reset_sequencer
(
  // Clock and synchronous system reset.
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Device pins.
  input wire logic reset_pin_n_in,
  input wire logic nmi_pin_in,
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe_out,
  // Processor side, same clock.
  input wire logic powerdown_request_bit_in,
  input wire logic halt_exec_in,
  input wire logic nmi_ack_in,
  // Status and control toward the rest of the device.
  output logic nmi_request_out,
  output logic clock_enable_out,
  output logic powerdown_out,
  output logic reset_out,
  output logic bus_abort_out,
  output logic pins_hold_out
);

  logic [pd_seq_pkg::SYNC_WIDTH-1:0] pins_sync;
  logic reset_active;
  logic nmi_level;
  logic timer_charged;
  pd_seq_pkg::seq_regs_t seq_reg;
  pd_seq_pkg::seq_regs_t seq_next;

  // All three pins cross into the clock domain before anything looks at them.
  pin_sync u_pin_sync
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pins_in({timer_pin_in, nmi_pin_in, reset_pin_n_in}),
    .pins_out(pins_sync)
  );

  // Decoded views of the synchronised pins.
  assign reset_active = ~pins_sync[pd_seq_pkg::SYNC_RESET_POS];
  assign nmi_level = pins_sync[pd_seq_pkg::SYNC_NMI_POS];
  assign timer_charged = pins_sync[pd_seq_pkg::SYNC_TIMER_POS];

  // Next-state logic for the whole sequencer.
  always_comb
  begin
    seq_next = seq_reg;
    seq_next.nmi_prev = nmi_level;
    seq_next.rst.reset_ind = 1'b0;
    seq_next.rst.bus_abort = 1'b0;
    seq_next.rst.pins_hold = 1'b0;
    // Latch a rising interrupt edge; a new edge wins over an acknowledge.
    if (nmi_level && !seq_reg.nmi_prev)
    begin
      seq_next.nmi_pending = 1'b1;
    end
    else if (nmi_ack_in)
    begin
      seq_next.nmi_pending = 1'b0;
    end
    // Reset is checked first so it overrides every state, powerdown included.
    if (reset_active)
    begin
      seq_next = pd_seq_pkg::SEQ_RESET_VALUE;
      seq_next.nmi_prev = nmi_level;
      seq_next.rst.reset_ind = 1'b1;
    end
    else
    begin
      case (seq_reg.state)
        pd_seq_pkg::st_run:
        begin
          // Halt alone only idles; the request bit must also be set.
          if (halt_exec_in && powerdown_request_bit_in)
          begin
            seq_next.state = pd_seq_pkg::st_powerdown;
            seq_next.clock_enable = 1'b0;
            seq_next.timer_oe = 1'b1;
            seq_next.timer_drive = 1'b0;
          end
        end
        pd_seq_pkg::st_powerdown:
        begin
          // The timer pin is held low so the capacitor starts discharged.
          // Only a fresh interrupt leaves here; reset is handled above.
          if (nmi_level && !seq_reg.nmi_prev)
          begin
            seq_next.state = pd_seq_pkg::st_restart;
            seq_next.timer_oe = 1'b1;
            seq_next.timer_drive = 1'b1;
          end
        end
        pd_seq_pkg::st_restart:
        begin
          // Clocks come back only once the capacitor has charged past the
          // input threshold, giving the oscillator time to settle.
          if (timer_charged)
          begin
            seq_next.state = pd_seq_pkg::st_run;
            seq_next.clock_enable = 1'b1;
            seq_next.timer_oe = 1'b0;
            seq_next.timer_drive = 1'b0;
          end
        end
        default:
        begin
          seq_next.state = pd_seq_pkg::st_run;
        end
      endcase
    end
  end

  // Single state register; the system reset loads the constant start value.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      seq_reg <= pd_seq_pkg::SEQ_RESET_VALUE;
    end
    else
    begin
      seq_reg <= seq_next;
    end
  end

  // Every output is a flip-flop of the state register, except powerdown_out, which is decoded from its state field.
  assign timer_pin_out = seq_reg.timer_drive;
  assign timer_pin_oe_out = seq_reg.timer_oe;
  assign nmi_request_out = seq_reg.nmi_pending;
  assign clock_enable_out = seq_reg.clock_enable;
  assign powerdown_out = (seq_reg.state == pd_seq_pkg::st_powerdown);
  assign reset_out = seq_reg.rst.reset_ind;
  assign bus_abort_out = seq_reg.rst.bus_abort;
  assign pins_hold_out = seq_reg.rst.pins_hold;

endmodule

// ==== hdl/pd_seq_pkg.sv ====
// Shared types and constants for the powerdown and reset sequencer.
package pd_seq_pkg;

  // Number of pins brought in through the synchroniser.
  localparam int SYNC_WIDTH = 3;
  // Bit positions of each pin within the synchronised vector.
  localparam int SYNC_RESET_POS = 0;
  localparam int SYNC_NMI_POS = 1;
  localparam int SYNC_TIMER_POS = 2;
  // Value of the synchroniser stages after reset: reset pin idle high,
  // interrupt idle low, timer pin taken as discharged.
  localparam logic [2:0] SYNC_RESET_VALUE = 3'h1;

  // Sequencer operating states.
  typedef enum logic [1:0] {
    st_run,
    st_powerdown,
    st_restart
  } seq_state_t;

  // Two stages of the pin synchroniser.
  typedef struct packed {
    logic [SYNC_WIDTH-1:0] first;
    logic [SYNC_WIDTH-1:0] second;
  } sync_state_t;

  // Outputs that show the device is in reset.
  typedef struct packed {
    logic reset_ind;
    logic bus_abort;
    logic pins_hold;
  } reset_ctrl_t;

  // Whole state of the sequencer.
  typedef struct packed {
    seq_state_t state;
    logic nmi_prev;
    logic nmi_pending;
    logic clock_enable;
    logic timer_oe;
    logic timer_drive;
    reset_ctrl_t rst;
  } seq_regs_t;

  // State after reset: running, clocks on, reset indicated for one cycle.
  localparam seq_regs_t SEQ_RESET_VALUE = '{
    state: st_run,
    nmi_prev: 1'b0,
    nmi_pending: 1'b0,
    clock_enable: 1'b1,
    timer_oe: 1'b0,
    timer_drive: 1'b0,
    rst: '{reset_ind: 1'b1, bus_abort: 1'b1, pins_hold: 1'b1}
  };

endpackage

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for the asynchronous pins of the sequencer.
`timescale 1ns/1ps
module pin_sync
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Raw pins and their synchronised copies.
  input wire logic [pd_seq_pkg::SYNC_WIDTH-1:0] pins_in,
  output logic [pd_seq_pkg::SYNC_WIDTH-1:0] pins_out
);

  pd_seq_pkg::sync_state_t sync_reg;
  pd_seq_pkg::sync_state_t sync_next;

  // The first stage feeds only the second, so metastability stays contained.
  always_comb
  begin
    sync_next.first = pins_in;
    sync_next.second = sync_reg.first;
  end

  // Both stages load a constant under reset.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      sync_reg.first <= pd_seq_pkg::SYNC_RESET_VALUE;
      sync_reg.second <= pd_seq_pkg::SYNC_RESET_VALUE;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign pins_out = sync_reg.second;

endmodule

// ==== sim/cap_model.sv ====
// Timing capacitor on the powerdown timer pin.
`timescale 1ns/1ps
module cap_model
#(
  parameter int CHARGE = 20
)
(
  // Pin drive from the device and level seen back.
  input wire logic clock_in,
  input wire logic oe_in,
  input wire logic drive_in,
  output logic level_out
);
  int q_reg = 0;
  // Driven high it charges slowly, driven low it empties at once.
  always @(posedge clock_in)
    if (oe_in)
      q_reg <= drive_in ? q_reg + 1 : 0;
  assign level_out = q_reg >= CHARGE;
endmodule

// ==== sim/powerdown_reset_sequencer_checker.sv ====
// Assertions on the ports of the powerdown sequencer.
`timescale 1ns/1ps
module powerdown_reset_sequencer_checker
(
  // All ports of the sequencer.
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_n_in,
  input wire logic nmi_pin_in,
  input wire logic timer_pin_in,
  input wire logic timer_pin_out,
  input wire logic timer_pin_oe_out,
  input wire logic powerdown_request_bit_in,
  input wire logic halt_exec_in,
  input wire logic nmi_ack_in,
  input wire logic nmi_request_out,
  input wire logic clock_enable_out,
  input wire logic powerdown_out,
  input wire logic reset_out,
  input wire logic bus_abort_out,
  input wire logic pins_hold_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // A short interrupt pulse, then quiet inputs while it is synchronised.
  sequence nmi_pulse;
    $rose(nmi_pin_in) && reset_pin_n_in ##1 !nmi_pin_in;
  endsequence
  sequence quiet3;
    (!nmi_ack_in && reset_pin_n_in)[*3];
  endsequence
  halt_entry_a: assert property (
    $rose(powerdown_out) |-> $past(halt_exec_in && powerdown_request_bit_in))
    else $error("powerdown without halt");
  exit_cause_a: assert property (
    $fell(powerdown_out) |-> $past(nmi_pin_in, 3) || !$past(reset_pin_n_in, 3))
    else $error("powerdown left without cause");
  restart_wait_a: assert property (
    $fell(powerdown_out) && !reset_out |->
      !clock_enable_out && timer_pin_oe_out && timer_pin_out)
    else $error("restart not timed");
  clock_on_a: assert property (
    $rose(clock_enable_out) && !reset_out |-> $past(timer_pin_in, 3))
    else $error("clock before timer charged");
  reset_hold_a: assert property (
    !reset_pin_n_in [*3] |=> reset_out && bus_abort_out && pins_hold_out)
    else $error("reset pin not obeyed");
  reset_release_a: assert property (
    $fell(reset_out) |-> $past(reset_pin_n_in, 2))
    else $error("reset indicator dropped early");
  no_delay_a: assert property (
    $fell(reset_out) |-> clock_enable_out && !timer_pin_oe_out && !powerdown_out)
    else $error("reset exit delayed");
  nmi_latch_a: assert property (
    nmi_pulse ##0 quiet3 |=> nmi_request_out)
    else $error("interrupt pulse lost");
endmodule
bind powerdown_reset_sequencer powerdown_reset_sequencer_checker
  powerdown_reset_sequencer_checker_i (.*);

// ==== sim/test_powerdown_reset_sequencer.sv ====
// Self-checking bench for the powerdown sequencer.
`timescale 1ns/1ps
module test_powerdown_reset_sequencer;
  localparam int CHARGE = 20;
  logic clock_in = 0, rst_n_in = 0, reset_pin_n_in = 1, nmi_pin_in = 0;
  logic powerdown_request_bit_in = 0, halt_exec_in = 0, nmi_ack_in = 0;
  logic timer_pin_in, timer_pin_out, timer_pin_oe_out, nmi_request_out;
  logic clock_enable_out, powerdown_out, reset_out, bus_abort_out;
  logic pins_hold_out;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  always #50 clock_in = ~clock_in;
  powerdown_reset_sequencer powerdown_reset_sequencer_i (.*);
  cap_model #(.CHARGE(CHARGE)) cap_model_i (.clock_in(clock_in),
    .oe_in(timer_pin_oe_out), .drive_in(timer_pin_out),
    .level_out(timer_pin_in));
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Halt with the request bit set puts the clocks to sleep.
  task automatic enter_pd;
    @(posedge clock_in) {powerdown_request_bit_in, halt_exec_in} <= 2'b11;
    @(posedge clock_in) halt_exec_in <= 0;
    #1;
    chk(powerdown_out, 1);
    chk(clock_enable_out, 0);
  endtask
  task automatic test_halt_ignored;
    @(posedge clock_in) {powerdown_request_bit_in, halt_exec_in} <= 2'b01;
    @(posedge clock_in) halt_exec_in <= 0;
    #1;
    chk(powerdown_out, 0);
    $display("halt without request bit done");
  endtask
  // A short interrupt pulse wakes the device after the capacitor charges.
  task automatic test_nmi_exit;
    int k;
    enter_pd();
    chk(timer_pin_oe_out, 1);
    step(6);
    chk(powerdown_out, 1);
    @(posedge clock_in) nmi_pin_in <= 1;
    @(posedge clock_in) nmi_pin_in <= 0;
    step(2);
    chk(powerdown_out, 0);
    chk(nmi_request_out, 1);
    chk(clock_enable_out, 0);
    chk(timer_pin_out, 1);
    for (k = 0; !clock_enable_out && k < 100; k++)
      step(1);
    chk(k >= CHARGE, 1);
    @(posedge clock_in) nmi_ack_in <= 1;
    @(posedge clock_in) nmi_ack_in <= 0;
    #1;
    chk(nmi_request_out, 0);
    $display("interrupt exit done");
  endtask
  // Reset together with an interrupt leaves powerdown with no delay.
  task automatic test_reset_exit;
    enter_pd();
    @(posedge clock_in) {reset_pin_n_in, nmi_pin_in} <= 2'b01;
    step(3);
    chk(reset_out, 1);
    chk(bus_abort_out, 1);
    chk(pins_hold_out, 1);
    chk(powerdown_out, 0);
    chk(clock_enable_out, 1);
    chk(timer_pin_oe_out, 0);
    step(4);
    chk(reset_out, 1);
    @(posedge clock_in) {reset_pin_n_in, nmi_pin_in} <= 2'b10;
    step(2);
    chk(reset_out, 1);
    step(1);
    chk(reset_out, 0);
    $display("reset exit done");
  endtask
  // Cut a hang short.
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1;
    step(2);
    test_halt_ignored();
    test_nmi_exit();
    test_reset_exit();
    report_and_stop();
  end
endmodule
